/* File: tcr_timer16_regs.v */
// 16-bit timer counter, capture, compare and mask registers behind the cpu bus
// Notes on behaviour
// R1 - force strobes are ignored unless the waveform mode is non-pwm
// R2 - writing a force bit forces a compare match on the output pin
// R3 - force bits are strobes using the output mode present at that moment
// R4 - forced match raises no interrupt and does not clear counter in ctc
// R5 - force bit positions always read zero
// R6 - counter low byte at base, high byte at base plus one, read/write
// R7 - all 16-bit accesses go through one shared 8-bit temporary high byte
// R8 - a counter write suppresses compare matches on the next timer tick
// R9 - software should not change the counter while it runs
// R10 - capture event copies counter into the capture register
// R11 - capture register is top only in ctc capture mode; other capture-top modes only block capture
// R12 - compare registers compared continuously; match flags and drives pin
// R13 - mask bits 5,2,1,0 gate interrupts with global enable and event flag
// R14 - counter, capture, compare a, compare b at 94,96,98,9a, reset zero
// R15 - write high first into temp, low write commits; low read latches high
`timescale 1ns/1ps
`default_nettype none
`include "tcr_map.vh"
module tcr_timer16_regs (
    input  wire       clk,
    input  wire       rst,
    input  wire [7:0] bus_addr,
    input  wire [7:0] bus_wdata,
    input  wire       bus_wr,
    input  wire       bus_rd,
    input  wire       timer_tick,
    input  wire [3:0] waveform_mode_field,
    input  wire [1:0] compare_output_mode_a,
    input  wire [1:0] compare_output_mode_b,
    input  wire       capture_evt,
    input  wire       global_irq_enable,
    input  wire       capture_event_flag,
    input  wire       match_a_flag,
    input  wire       match_b_flag,
    input  wire       overflow_flag,
    output reg  [7:0] bus_rdata_q,
    output reg  [15:0] counter_value_q,
    output reg  [15:0] capture_value_q,
    output reg  [15:0] compare_a_value_q,
    output reg  [15:0] compare_b_value_q,
    output reg  [7:0] timer_interrupt_mask_q,
    output reg        match_a_evt_q,
    output reg        match_b_evt_q,
    output reg        capture_irq_q,
    output reg        match_a_irq_q,
    output reg        match_b_irq_q,
    output reg        overflow_irq_q,
    output wire       wave_out_a_pin,
    output wire       wave_out_b_pin
);
    reg  [7:0]  temp_high_q;
    reg         block_match_q;
    reg  [15:0] top_value;
    reg         force_a;
    reg         force_b;
    reg         non_pwm;
    reg         capture_is_top;
    reg  [7:0]  rdata_d;
    wire        hit_a;
    wire        hit_b;
    wire        at_top;

    function is_low;
        input [7:0] a;
        input [7:0] base;
        is_low = (a == base);
    endfunction
    function is_high;
        input [7:0] a;
        input [7:0] base;
        is_high = (a == base + `TCR_HI_OFS);
    endfunction

    always @* begin
        non_pwm = (waveform_mode_field == `TCR_MODE_NORMAL) ||
                  (waveform_mode_field == `TCR_MODE_CTC_A) ||
                  (waveform_mode_field == `TCR_MODE_CTC_CAP);
        capture_is_top = (waveform_mode_field == `TCR_MODE_CTC_CAP) ||
                         (waveform_mode_field == `TCR_MODE_PFC_CAP) ||
                         (waveform_mode_field == `TCR_MODE_PC_CAP) ||
                         (waveform_mode_field == `TCR_MODE_FAST_CAP); // R11
        if (capture_is_top) begin
            top_value = capture_value_q; // R11
        end else if (waveform_mode_field == `TCR_MODE_CTC_A) begin
            top_value = compare_a_value_q;
        end else begin
            top_value = 16'hFFFF;
        end
        force_a = bus_wr && is_low(bus_addr, `TCR_OFS_CTRL_C) && non_pwm &&
                  bus_wdata[`TCR_FORCE_A_BIT]; // R1
        force_b = bus_wr && is_low(bus_addr, `TCR_OFS_CTRL_C) && non_pwm &&
                  bus_wdata[`TCR_FORCE_B_BIT]; // R1
    end

    // blocked tick after a counter write keeps a rewritten value from matching
    assign hit_a = timer_tick && !block_match_q &&
                   (counter_value_q == compare_a_value_q); // R8 R12
    assign hit_b = timer_tick && !block_match_q &&
                   (counter_value_q == compare_b_value_q); // R8 R12
    assign at_top = (counter_value_q == top_value);

    always @* begin
        rdata_d = `TCR_RESET8;
        if (is_low(bus_addr, `TCR_OFS_CNT)) rdata_d = counter_value_q[7:0];
        else if (is_low(bus_addr, `TCR_OFS_CAP)) rdata_d = capture_value_q[7:0];
        else if (is_low(bus_addr, `TCR_OFS_CMPA)) rdata_d = compare_a_value_q[7:0];
        else if (is_low(bus_addr, `TCR_OFS_CMPB)) rdata_d = compare_b_value_q[7:0];
        else if (is_high(bus_addr, `TCR_OFS_CNT) ||
                 is_high(bus_addr, `TCR_OFS_CAP) ||
                 is_high(bus_addr, `TCR_OFS_CMPA) ||
                 is_high(bus_addr, `TCR_OFS_CMPB)) rdata_d = temp_high_q; // R7
        else if (is_low(bus_addr, `TCR_OFS_MASK)) rdata_d = timer_interrupt_mask_q;
        else if (is_low(bus_addr, `TCR_OFS_CTRL_C)) rdata_d = `TCR_RESET8; // R5
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_rdata_q            <= `TCR_RESET8;
            temp_high_q            <= `TCR_RESET8;
            counter_value_q        <= `TCR_RESET16; // R14
            capture_value_q        <= `TCR_RESET16;
            compare_a_value_q      <= `TCR_RESET16;
            compare_b_value_q      <= `TCR_RESET16;
            timer_interrupt_mask_q <= `TCR_RESET8;
            block_match_q          <= 1'b0;
            match_a_evt_q          <= 1'b0;
            match_b_evt_q          <= 1'b0;
            capture_irq_q          <= 1'b0;
            match_a_irq_q          <= 1'b0;
            match_b_irq_q          <= 1'b0;
            overflow_irq_q         <= 1'b0;
        end else begin
            if (bus_rd) begin
                bus_rdata_q <= rdata_d;
            end
            // low read snapshots the high byte so the pair stays coherent
            if (bus_rd && is_low(bus_addr, `TCR_OFS_CNT))
                temp_high_q <= counter_value_q[15:8]; // R15
            else if (bus_rd && is_low(bus_addr, `TCR_OFS_CAP))
                temp_high_q <= capture_value_q[15:8]; // R15
            else if (bus_rd && is_low(bus_addr, `TCR_OFS_CMPA))
                temp_high_q <= compare_a_value_q[15:8];
            else if (bus_rd && is_low(bus_addr, `TCR_OFS_CMPB))
                temp_high_q <= compare_b_value_q[15:8];
            else if (bus_wr && (is_high(bus_addr, `TCR_OFS_CNT) ||
                     is_high(bus_addr, `TCR_OFS_CAP) ||
                     is_high(bus_addr, `TCR_OFS_CMPA) ||
                     is_high(bus_addr, `TCR_OFS_CMPB)))
                temp_high_q <= bus_wdata; // R7 R15

            // cpu write wins over counting in the same cycle
            if (bus_wr && is_low(bus_addr, `TCR_OFS_CNT)) begin
                counter_value_q <= {temp_high_q, bus_wdata}; // R6 R15
                block_match_q   <= 1'b1; // R8
            end else if (timer_tick) begin
                block_match_q <= 1'b0;
                // forced matches never reach this clear path
                if (non_pwm && at_top && waveform_mode_field != `TCR_MODE_NORMAL)
                    counter_value_q <= `TCR_RESET16; // R4
                else
                    counter_value_q <= counter_value_q + 16'h0001;
            end

            // capture disconnected while the capture register is top
            if (capture_evt && !capture_is_top)
                capture_value_q <= counter_value_q; // R10
            else if (bus_wr && is_low(bus_addr, `TCR_OFS_CAP))
                capture_value_q <= {temp_high_q, bus_wdata}; // R15
            if (bus_wr && is_low(bus_addr, `TCR_OFS_CMPA))
                compare_a_value_q <= {temp_high_q, bus_wdata}; // R15
            if (bus_wr && is_low(bus_addr, `TCR_OFS_CMPB))
                compare_b_value_q <= {temp_high_q, bus_wdata}; // R15
            if (bus_wr && is_low(bus_addr, `TCR_OFS_MASK))
                timer_interrupt_mask_q <= bus_wdata & `TCR_MASK_RW; // R13

            match_a_evt_q <= hit_a; // R4 R12
            match_b_evt_q <= hit_b; // R4 R12
            capture_irq_q  <= global_irq_enable && capture_event_flag &&
                timer_interrupt_mask_q[`TCR_IE_CAP_BIT]; // R13
            match_a_irq_q  <= global_irq_enable && match_a_flag &&
                timer_interrupt_mask_q[`TCR_IE_MA_BIT]; // R13
            match_b_irq_q  <= global_irq_enable && match_b_flag &&
                timer_interrupt_mask_q[`TCR_IE_MB_BIT]; // R13
            overflow_irq_q <= global_irq_enable && overflow_flag &&
                timer_interrupt_mask_q[`TCR_IE_OV_BIT]; // R13
        end
    end

    tcr_wave_out u_wave_a (
        .clk                 (clk),
        .rst                 (rst),
        .match_evt           (hit_a | force_a), // R2 R3
        .compare_output_mode (compare_output_mode_a),
        .wave_out_q          (wave_out_a_pin)
    );
    tcr_wave_out u_wave_b (
        .clk                 (clk),
        .rst                 (rst),
        .match_evt           (hit_b | force_b), // R2 R3
        .compare_output_mode (compare_output_mode_b),
        .wave_out_q          (wave_out_b_pin)
    );
endmodule // tcr_timer16_regs
`default_nettype wire

/* File: tcr_map.vh */
// register map and field constants for the 16-bit timer register block
`ifndef TCR_MAP_VH
`define TCR_MAP_VH
`define TCR_ADDR_W        8
`define TCR_OFS_CTRL_C    8'h92
`define TCR_OFS_MASK      8'h71
`define TCR_OFS_CNT       8'h94
`define TCR_OFS_CAP       8'h96
`define TCR_OFS_CMPA      8'h98
`define TCR_OFS_CMPB      8'h9A
`define TCR_HI_OFS        8'h01
`define TCR_FORCE_A_BIT   7
`define TCR_FORCE_B_BIT   6
`define TCR_IE_CAP_BIT    5
`define TCR_IE_MB_BIT     2
`define TCR_IE_MA_BIT     1
`define TCR_IE_OV_BIT     0
`define TCR_MASK_RW       8'h27
`define TCR_RESET16       16'h0000
`define TCR_RESET8        8'h00
`define TCR_MODE_NORMAL   4'h0
`define TCR_MODE_CTC_A    4'h4
`define TCR_MODE_CTC_CAP  4'hC
`define TCR_MODE_PFC_CAP  4'h8
`define TCR_MODE_PC_CAP   4'hA
`define TCR_MODE_FAST_CAP 4'hE
`define TCR_COM_TOGGLE    2'h1
`define TCR_COM_CLEAR     2'h2
`define TCR_COM_SET       2'h3
`endif

/* File: tcr_wave_out.v */
// one compare output: applies the compare output mode on a real or forced match
`timescale 1ns/1ps
`default_nettype none
`include "tcr_map.vh"
module tcr_wave_out (
    input  wire       clk,
    input  wire       rst,
    input  wire       match_evt,
    input  wire [1:0] compare_output_mode,
    output reg        wave_out_q
);
    reg wave_d;
    always @* begin
        wave_d = wave_out_q;
        if (match_evt) begin
            case (compare_output_mode)
                `TCR_COM_TOGGLE: wave_d = ~wave_out_q;
                `TCR_COM_CLEAR:  wave_d = 1'b0;
                `TCR_COM_SET:    wave_d = 1'b1;
                default:         wave_d = wave_out_q;
            endcase
        end
    end
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wave_out_q <= 1'b0;
        end else begin
            wave_out_q <= wave_d;
        end
    end
endmodule // tcr_wave_out
`default_nettype wire

/* File: tcr_cpu_model.sv */
// cpu-side model issuing single-cycle register reads and writes
`timescale 1ns/1ps
`default_nettype none
module tcr_cpu_model (
    input  wire logic       clk,
    input  wire logic [7:0] bus_rdata_q,
    output var  logic [7:0] bus_addr,
    output var  logic [7:0] bus_wdata,
    output var  logic       bus_wr,
    output var  logic       bus_rd
);
    initial {bus_addr, bus_wdata, bus_wr, bus_rd} = 18'h00000;
    task automatic xfer(input logic w, input logic [7:0] a, v,
                        output logic [7:0] q);
        @(negedge clk);
        {bus_wr, bus_rd, bus_addr, bus_wdata} = {w, !w, a, v};
        @(negedge clk);
        q = bus_rdata_q;
        // released data is scrambled so a stale value never passes
        {bus_wr, bus_rd, bus_wdata} = {2'b00, ~v};
    endtask
endmodule // tcr_cpu_model
`default_nettype wire

/* File: tcr_timer16_regs_assertions.sv */
// port-level checks on the 16-bit timer register block
`timescale 1ns/1ps
`default_nettype none
`include "tcr_map.vh"
module tcr_timer16_regs_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  bus_addr,
    input wire logic [7:0]  bus_wdata,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic        timer_tick,
    input wire logic [3:0]  waveform_mode_field,
    input wire logic [1:0]  compare_output_mode_a,
    input wire logic        global_irq_enable,
    input wire logic        capture_event_flag,
    input wire logic [7:0]  bus_rdata_q,
    input wire logic [15:0] counter_value_q,
    input wire logic [7:0]  timer_interrupt_mask_q,
    input wire logic        match_a_evt_q,
    input wire logic        match_b_evt_q,
    input wire logic        capture_irq_q,
    input wire logic        wave_out_a_pin,
    input wire logic        wave_out_b_pin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_force_reads_zero: assert property (
        bus_rd && bus_addr == `TCR_OFS_CTRL_C |=> bus_rdata_q == 8'h00)
        else $error("force bit position read back nonzero");
    a_mask_reserved_low: assert property (
        (timer_interrupt_mask_q & ~`TCR_MASK_RW) == 8'h00)
        else $error("reserved mask bit set");
    a_capture_irq_gate: assert property (
        capture_irq_q == $past(global_irq_enable && capture_event_flag
        && timer_interrupt_mask_q[`TCR_IE_CAP_BIT]))
        else $error("capture interrupt not gated");
    a_low_write_commit: assert property (
        bus_wr && bus_addr == `TCR_OFS_CNT
        |=> counter_value_q[7:0] == $past(bus_wdata))
        else $error("counter low byte not committed");
    a_match_needs_tick: assert property (
        !timer_tick |=> !match_a_evt_q && !match_b_evt_q)
        else $error("match event without a timer tick");
    a_write_blocks_match: assert property (
        bus_wr && bus_addr == `TCR_OFS_CNT ##1 timer_tick
        |=> !match_a_evt_q && !match_b_evt_q)
        else $error("match right after counter write");
    a_force_toggles_pin: assert property (
        bus_wr && bus_addr == `TCR_OFS_CTRL_C && bus_wdata[7] && !timer_tick
        && waveform_mode_field == 4'h0 && compare_output_mode_a == 2'h1
        |=> wave_out_a_pin != $past(wave_out_a_pin))
        else $error("forced toggle did not move output a");
    a_force_pwm_ignored: assert property (
        bus_wr && bus_addr == `TCR_OFS_CTRL_C && !timer_tick
        && !(waveform_mode_field inside {4'h0, 4'h4, 4'hC})
        |=> $stable(wave_out_a_pin) && $stable(wave_out_b_pin))
        else $error("force strobe acted in a pwm mode");
endmodule // tcr_timer16_regs_chk
bind tcr_timer16_regs tcr_timer16_regs_chk u_chk (.*);
`default_nettype wire

/* File: tb_tcr_timer16_regs.sv */
// self-checking bench for the 16-bit timer register block
`timescale 1ns/1ps
`default_nettype none
`include "tcr_map.vh"
module tb_tcr_timer16_regs;
    logic        clk = 0, rst = 1, tick = 0, cap = 0, gie = 0, capf = 0;
    logic        maf = 0, mbf = 0, ovf = 0;
    logic [3:0]  mode = 4'h0;
    logic [1:0]  coma = 2'h0, comb = 2'h0;
    logic [7:0]  addr, wdata, rdata, d, mask;
    logic        wr_s, rd_s, evt_a, evt_b, pin_a, pin_b, irq_c;
    logic        irq_a, irq_b, irq_o;
    logic [15:0] cnt, capv, cmpa, cmpb;
    logic [7:0]  base [4] = '{`TCR_OFS_CNT, `TCR_OFS_CAP, `TCR_OFS_CMPA,
                              `TCR_OFS_CMPB};
    int          failures = 0, cmp_count = 0, evt_n = 0, evt_bn = 0;
    tcr_cpu_model u_cpu (.clk(clk), .bus_rdata_q(rdata), .bus_addr(addr),
        .bus_wdata(wdata), .bus_wr(wr_s), .bus_rd(rd_s));
    tcr_timer16_regs dut_u (.clk(clk), .rst(rst), .bus_addr(addr),
        .bus_wdata(wdata), .bus_wr(wr_s), .bus_rd(rd_s), .timer_tick(tick),
        .waveform_mode_field(mode), .compare_output_mode_a(coma),
        .compare_output_mode_b(comb), .capture_evt(cap),
        .global_irq_enable(gie), .capture_event_flag(capf),
        .match_a_flag(maf), .match_b_flag(mbf), .overflow_flag(ovf),
        .bus_rdata_q(rdata), .counter_value_q(cnt), .capture_value_q(capv),
        .compare_a_value_q(cmpa), .compare_b_value_q(cmpb),
        .timer_interrupt_mask_q(mask), .match_a_evt_q(evt_a),
        .match_b_evt_q(evt_b), .capture_irq_q(irq_c),
        .match_a_irq_q(irq_a), .match_b_irq_q(irq_b),
        .overflow_irq_q(irq_o), .wave_out_a_pin(pin_a),
        .wave_out_b_pin(pin_b));
    task automatic chk(input string n, input logic [15:0] e, g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, v);
        u_cpu.xfer(1'b1, a, v, d);
    endtask
    task automatic rd(input logic [7:0] a);
        u_cpu.xfer(1'b0, a, 8'h00, d);
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a + 8'h01, v[15:8]);
        wr(a, v[7:0]);
    endtask
    initial forever #50 clk = ~clk;
    // sampled on the falling edge, clear of the update edge
    always @(negedge clk) if (evt_a === 1'b1) evt_n++;
    always @(negedge clk) if (evt_b === 1'b1) evt_bn++;
    initial begin
        #300000;
        failures++;
        test_done;
    end
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(base[i]);
            chk("low reset", 16'h0, d);
            rd(base[i] + 8'h01);
            chk("high reset", 16'h0, d);
            wr16(base[i], {8'hA0, 8'(i)});
            rd(base[i]);
            chk("low back", 16'(i), d);
            rd(base[i] + 8'h01);
            chk("high back", 16'hA0, d);
        end
        chk("cmpb", 16'hA003, cmpb);
        wr(`TCR_OFS_CMPA + 8'h01, 8'h3C);
        wr(`TCR_OFS_CNT, 8'h07);
        chk("shared temp", 16'h3C07, cnt);
        rd(`TCR_OFS_MASK);
        chk("mask reset", 16'h0, d);
        wr(`TCR_OFS_MASK, 8'hFF);
        rd(`TCR_OFS_MASK);
        chk("mask rw", `TCR_MASK_RW, d);
        {gie, capf, maf, mbf, ovf} = 5'b11111;
        repeat (2) @(negedge clk);
        chk("irq on", 16'h1, irq_c);
        chk("irq a on", 16'h1, irq_a);
        chk("irq b on", 16'h1, irq_b);
        chk("irq ov on", 16'h1, irq_o);
        gie = 1'b0;
        repeat (2) @(negedge clk);
        chk("irq off", 16'h0, irq_c);
        chk("irq a off", 16'h0, irq_a);
        chk("irq b off", 16'h0, irq_b);
        chk("irq ov off", 16'h0, irq_o);
        $display("test registers done");
        {coma, comb} = {`TCR_COM_TOGGLE, `TCR_COM_SET};
        wr(`TCR_OFS_CTRL_C, 8'hC0);
        chk("force a", 16'h1, pin_a);
        chk("force b", 16'h1, pin_b);
        mode = 4'h5;
        wr(`TCR_OFS_CTRL_C, 8'h80);
        chk("pwm ignored", 16'h1, pin_a);
        {mode, coma} = {`TCR_MODE_CTC_A, `TCR_COM_CLEAR};
        wr(`TCR_OFS_CTRL_C, 8'h80);
        chk("force clear", 16'h0, pin_a);
        chk("no clear", 16'h3C07, cnt);
        rd(`TCR_OFS_CTRL_C);
        chk("force read", 16'h0, d);
        chk("no event", 16'h0, 16'(evt_n));
        mode = `TCR_MODE_NORMAL;
        wr16(`TCR_OFS_CMPA, 16'h0005);
        wr16(`TCR_OFS_CNT, 16'h0005);
        tick = 1'b1;
        @(negedge clk) tick = 1'b0;
        repeat (2) @(negedge clk);
        chk("blocked", 16'h0, 16'(evt_n));
        wr16(`TCR_OFS_CNT, 16'h0003);
        repeat (5) begin
            @(negedge clk) tick = 1'b1;
            @(negedge clk) tick = 1'b0;
        end
        chk("count", 16'h0008, cnt);
        chk("one match", 16'h1, 16'(evt_n));
        chk("no b match", 16'h0, 16'(evt_bn));
        cap = 1'b1;
        @(negedge clk) cap = 1'b0;
        chk("capture", 16'h0008, capv);
        mode = `TCR_MODE_CTC_CAP;
        wr16(`TCR_OFS_CNT, 16'h0022);
        cap = 1'b1;
        @(negedge clk) cap = 1'b0;
        chk("capture as top", 16'h0008, capv);
        mode = `TCR_MODE_FAST_CAP;
        cap = 1'b1;
        @(negedge clk) cap = 1'b0;
        chk("capture top fast", 16'h0008, capv);
        mode = `TCR_MODE_NORMAL;
        cap = 1'b1;
        @(negedge clk) cap = 1'b0;
        chk("capture again", 16'h0022, capv);
        $display("test timer done");
        test_done;
    end
endmodule // tb_tcr_timer16_regs
`default_nettype wire
